// file: rtl/plc_arith_move_unit.sv
// signed move and arithmetic datapath for the ladder scan controller
`timescale 1ns/1ps
`default_nettype none
module plc_arith_move_unit (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic scan_tick,
   input wire logic exec_cond,
   input wire arith_move_pkg::instr_t instr,
   output var arith_move_pkg::result_t result,
   output logic result_valid,
   output logic [3:0] step_count
);
   import arith_move_pkg::*;

   logic cond_prev_q;
   logic fire;
   logic [WIDE_W:0] sum_ext;
   logic [WIDE_W:0] diff_ext;
   logic signed [WIDE_W-1:0] s1_n;
   logic signed [WIDE_W-1:0] s2_n;
   logic signed [2*WIDE_W-1:0] prod_full;
   logic signed [WIDE_W-1:0] quot;
   logic signed [WIDE_W-1:0] remd;
   logic ovf_hi;
   logic ovf_lo;
   logic [WIDE_W:0] arith_ext;
   logic valid_q;
   logic [WIDE_W-1:0] dest_lo_q;
   logic [WIDE_W-1:0] dest_hi_q;
   logic wr_hi_q;
   logic zero_q;
   logic borrow_q;
   logic carry_q;

   // narrow forms see only the low word, sign from bit 15
   function automatic logic signed [WIDE_W-1:0] sext(input logic [WIDE_W-1:0] v,
                                                      input logic wide);
      if (wide) begin
         sext = v;
      end else begin
         sext = {{(WIDE_W-WORD_W){v[WORD_W-1]}}, v[WORD_W-1:0]};
      end
   endfunction : sext

   // edge detect of the condition, updated only on scan ticks
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cond_prev_q <= 1'b0;
      end else if (scan_tick) begin
         cond_prev_q <= exec_cond;
      end
   end

   // continuous form fires every scan, pulse form on rising condition
   assign fire = scan_tick && exec_cond && (!instr.pulse || !cond_prev_q);

   assign s1_n = sext(instr.src1, instr.wide);
   assign s2_n = sext(instr.src2, instr.wide);
   assign sum_ext = {s1_n[WIDE_W-1], s1_n} + {s2_n[WIDE_W-1], s2_n};
   assign diff_ext = {s1_n[WIDE_W-1], s1_n} - {s2_n[WIDE_W-1], s2_n};
   assign prod_full = s1_n * s2_n;
   // divide by zero yields zero rather than an undefined value; an if keeps the
   // division signed, a literal arm of a conditional would make it unsigned
   always_comb begin
      if (s2_n == '0) begin
         quot = '0;
         remd = '0;
      end else begin
         quot = s1_n / s2_n;
         remd = s1_n % s2_n;
      end
   end
   assign arith_ext = (instr.op == OP_SUM) ? sum_ext : diff_ext;

   // range check against 16-bit or 32-bit signed limits
   always_comb begin
      if (instr.wide) begin
         ovf_hi = !arith_ext[WIDE_W] && arith_ext[WIDE_W-1];
         ovf_lo = arith_ext[WIDE_W] && !arith_ext[WIDE_W-1];
      end else begin
         ovf_hi = !arith_ext[WIDE_W] && (arith_ext[WIDE_W-1:WORD_W-1] != '0);
         ovf_lo = arith_ext[WIDE_W] && (arith_ext[WIDE_W-1:WORD_W-1] != '1);
      end
   end

   // destination words hold their value unless the instruction fires
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dest_lo_q <= RESULT_RESET;
         dest_hi_q <= RESULT_RESET;
         wr_hi_q <= 1'b0;
      end else if (fire) begin
         wr_hi_q <= 1'b0;
         case (instr.op)
            OP_COPY: begin
               dest_lo_q <= instr.wide ? instr.src1 : sext(instr.src1, 1'b0);
            end
            OP_SUM, OP_DIFF: begin
               dest_lo_q <= instr.wide ? arith_ext[WIDE_W-1:0]
                  : sext(arith_ext[WIDE_W-1:0], 1'b0);
            end
            OP_PROD: begin
               wr_hi_q <= 1'b1;
               if (instr.wide) begin
                  dest_lo_q <= prod_full[WIDE_W-1:0];
                  dest_hi_q <= prod_full[2*WIDE_W-1:WIDE_W];
               end else begin
                  dest_lo_q <= sext(prod_full[WIDE_W-1:0], 1'b0);
                  dest_hi_q <= sext({{(WIDE_W-WORD_W){1'b0}}, prod_full[WIDE_W-1:WORD_W]},
                     1'b0);
               end
            end
            OP_QUOT: begin
               wr_hi_q <= 1'b1;
               dest_lo_q <= instr.wide ? quot : sext(quot, 1'b0);
               dest_hi_q <= instr.wide ? remd : sext(remd, 1'b0);
            end
            default: begin
               dest_lo_q <= dest_lo_q;
            end
         endcase
      end
   end

   // flags move only on an executed sum or difference
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         zero_q <= 1'b0;
         borrow_q <= 1'b0;
         carry_q <= 1'b0;
      end else if (fire && (instr.op == OP_SUM || instr.op == OP_DIFF)) begin
         zero_q <= instr.wide ? (arith_ext[WIDE_W-1:0] == '0)
            : (arith_ext[WORD_W-1:0] == '0);
         borrow_q <= ovf_lo;
         carry_q <= ovf_hi;
      end
   end

   // flops gathered into the carrier, so each field keeps a single driver
   assign result = '{
      dest_lo: dest_lo_q,
      dest_hi: dest_hi_q,
      wr_hi: wr_hi_q,
      zero_result_flag: zero_q,
      borrow_flag: borrow_q,
      carry_flag: carry_q
   };

   // one-cycle strobe that a destination was written
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         valid_q <= 1'b0;
      end else begin
         valid_q <= fire;
      end
   end
   assign result_valid = valid_q;

   // program length of the presented instruction
   always_comb begin
      if (instr.op == OP_COPY) begin
         step_count = instr.wide ? STEPS_COPY_WIDE : STEPS_COPY;
      end else begin
         step_count = instr.wide ? STEPS_ARITH_WIDE : STEPS_ARITH;
      end
   end

   sum_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
      fire && instr.op == OP_SUM && !instr.wide && sum_ext[WORD_W-1:0] == '0
      |=> result.zero_result_flag)
      else $error("zero flag not set after zero sum");
   hold_dest_a: assert property (@(posedge clock) disable iff (!rst_n)
      !fire |=> $stable(result.dest_lo))
      else $error("destination changed without execution");
   flag_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(fire && (instr.op == OP_SUM || instr.op == OP_DIFF)) |=> $stable(result.carry_flag)
      && $stable(result.borrow_flag) && $stable(result.zero_result_flag))
      else $error("flags changed without sum or difference");
   // pulse form: a fired pulse followed at once by a held true scan must stay quiet
   sequence pulse_fired_s;
      fire && instr.pulse;
   endsequence
   sequence pulse_held_s;
      scan_tick && exec_cond && instr.pulse && $stable(exec_cond);
   endsequence

   pulse_once_a: assert property (@(posedge clock) disable iff (!rst_n)
      pulse_fired_s ##1 pulse_held_s |-> !fire)
      else $error("pulse form fired twice");
   copy_val_a: assert property (@(posedge clock) disable iff (!rst_n)
      fire && instr.op == OP_COPY && instr.wide |=> result.dest_lo == $past(instr.src1))
      else $error("copy value wrong");
   cont_rep_a: assert property (@(posedge clock) disable iff (!rst_n)
      scan_tick && exec_cond && !instr.pulse |=> result_valid)
      else $error("continuous form did not execute");
   carry_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      fire && instr.op == OP_SUM && !instr.wide && $signed(sum_ext) > 33'sd32767
      |=> result.carry_flag)
      else $error("carry flag missing");
   step_len_a: assert property (@(posedge clock) disable iff (!rst_n)
      instr.op == OP_SUM && !instr.wide |-> step_count == STEPS_ARITH)
      else $error("arithmetic step count wrong");

   // further checks on flags, word pairing and program length
   borrow_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      fire && (instr.op == OP_SUM || instr.op == OP_DIFF) && !instr.wide
      && $signed(arith_ext) < -33'sd32768 |=> result.borrow_flag)
      else $error("borrow flag missing");
   prod_split_a: assert property (@(posedge clock) disable iff (!rst_n)
      fire && instr.op == OP_PROD && !instr.wide |=> $signed({result.dest_hi[WORD_W-1:0],
      result.dest_lo[WORD_W-1:0]}) == $past(s1_n) * $past(s2_n))
      else $error("product words wrong");
   // divide by minus one is left out, its narrow quotient cannot be held
   quot_pair_a: assert property (@(posedge clock) disable iff (!rst_n)
      fire && instr.op == OP_QUOT && s2_n != '0 && s2_n != '1 |=> $past(s1_n)
      == $signed(result.dest_lo) * $past(s2_n) + $signed(result.dest_hi))
      else $error("quotient and remainder do not pair");
   copy_steps_a: assert property (@(posedge clock) disable iff (!rst_n)
      instr.op == OP_COPY && instr.wide |-> step_count == STEPS_COPY_WIDE)
      else $error("wide copy step count wrong");
   wide_steps_a: assert property (@(posedge clock) disable iff (!rst_n)
      instr.op != OP_COPY && instr.wide |-> step_count == STEPS_ARITH_WIDE)
      else $error("wide arithmetic step count wrong");
endmodule : plc_arith_move_unit
`default_nettype wire

// file: rtl/arith_move_pkg.sv
// constants, opcodes and carrier types for the ladder arithmetic and move unit
// Overview of operation
// - copy writes source unchanged to destination
// - false condition leaves destination unchanged
// - continuous and pulse form of every instruction
// - continuous form repeats every scan while enabled
// - arithmetic takes 7 steps, wide 13
// - copy takes 5 steps, wide 9
// - sum adds two signed sources
// - difference subtracts second source from first
// - operand top bit is the sign
// - zero result sets zero flag
// - result below -32768 sets borrow flag
// - result above 32767 sets carry flag
// - product multiplies two signed sources
// - low product word first, high next
// - top bit of product gives sign
// - quotient divides, stores quotient and remainder
// - quotient first word, remainder next word
package arith_move_pkg;
   localparam int WORD_W = 16;
   localparam int WIDE_W = 32;
   // program step lengths per instruction form
   localparam logic [3:0] STEPS_ARITH = 4'h7;
   localparam logic [3:0] STEPS_ARITH_WIDE = 4'hD;
   localparam logic [3:0] STEPS_COPY = 4'h5;
   localparam logic [3:0] STEPS_COPY_WIDE = 4'h9;
   localparam logic [WIDE_W-1:0] RESULT_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      OP_COPY = 3'b000,
      OP_SUM = 3'b001,
      OP_DIFF = 3'b010,
      OP_PROD = 3'b011,
      OP_QUOT = 3'b100
   } opcode_t;

   // one instruction as issued by the scan sequencer
   typedef struct packed {
      opcode_t op;
      logic wide;
      logic pulse;
      logic [WIDE_W-1:0] src1;
      logic [WIDE_W-1:0] src2;
   } instr_t;

   // destination words plus result flags
   typedef struct packed {
      logic [WIDE_W-1:0] dest_lo;
      logic [WIDE_W-1:0] dest_hi;
      logic wr_hi;
      logic zero_result_flag;
      logic borrow_flag;
      logic carry_flag;
   } result_t;
endpackage : arith_move_pkg

// file: verif/scan_sequencer_model.sv
// behavioural ladder scan sequencer issuing one instruction per scan tick
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer_model (
   input wire logic clock,
   output logic scan_tick,
   output logic exec_cond,
   output var arith_move_pkg::instr_t instr
);
   import arith_move_pkg::*;
   // idle at time zero
   initial begin
      scan_tick = 1'b0;
      exec_cond = 1'b0;
      instr = '0;
   end
   // destination is always a writable word in this model; n back-to-back scans
   task automatic issue_burst(input opcode_t op, input logic w, input logic p,
      input logic [31:0] a, input logic [31:0] b, input logic c, input int n);
      @(negedge clock);
      scan_tick <= 1'b1;
      exec_cond <= c;
      instr <= '{op: op, wide: w, pulse: p, src1: a, src2: b};
      repeat (n) @(negedge clock);
      scan_tick <= 1'b0;
      // operands are not held past the tick, so scramble them
      instr.src1 <= ~a;
      instr.src2 <= ~b;
   endtask : issue_burst
   // a single scan
   task automatic issue(input opcode_t op, input logic w, input logic p,
      input logic [31:0] a, input logic [31:0] b, input logic c);
      issue_burst(op, w, p, a, b, c, 1);
   endtask : issue
endmodule : scan_sequencer_model
`default_nettype wire

// file: verif/plc_arith_move_unit_tb.sv
// self-checking bench for the ladder arithmetic and move unit
`timescale 1ns/1ps
`default_nettype none
module plc_arith_move_unit_tb;
   import arith_move_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic scan_tick;
   logic exec_cond;
   instr_t instr;
   result_t result;
   logic result_valid;
   logic [3:0] step_count;
   int num_errors = 0;
   int checks = 0;
   always #25 clock = ~clock;
   scan_sequencer_model u_scan_sequencer_model (.clock(clock), .scan_tick(scan_tick),
      .exec_cond(exec_cond), .instr(instr));
   plc_arith_move_unit u_plc_arith_move_unit (.clock(clock), .rst_n(rst_n),
      .scan_tick(scan_tick), .exec_cond(exec_cond), .instr(instr), .result(result),
      .result_valid(result_valid), .step_count(step_count));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // narrow results judged on the low word only, full word when wide, copy or held
   task automatic run(input opcode_t op, input logic w, input logic p, input logic [31:0] a,
      input logic [31:0] b, input logic c, input logic v, input logic [31:0] lo,
      input logic [31:0] hi, input logic [2:0] f);
      logic [31:0] m;
      m = (w || op == OP_COPY || !v) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      u_scan_sequencer_model.issue(op, w, p, a, b, c);
      chk({31'h0, result_valid}, {31'h0, v});
      chk(result.dest_lo & m, lo & m);
      if (v && (op == OP_PROD || op == OP_QUOT)) begin
         chk(result.dest_hi & m, hi & m);
         chk({31'h0, result.wr_hi}, 32'h1);
      end else if (v) begin
         chk({31'h0, result.wr_hi}, 32'h0);
      end
      chk({29'h0, result.zero_result_flag, result.borrow_flag, result.carry_flag}, {29'h0, f});
   endtask : run
   task automatic copy_case;
      run(OP_COPY, 0, 0, 32'h0000_8001, 0, 1, 1, 32'hFFFF_8001, 0, 0);
      chk({28'h0, step_count}, 32'h5);
      run(OP_COPY, 1, 0, 32'h1234_5678, 0, 1, 1, 32'h1234_5678, 0, 0);
      chk({28'h0, step_count}, 32'h9);
      run(OP_COPY, 0, 0, 32'h0000_0042, 0, 0, 0, 32'h1234_5678, 0, 0);
   endtask : copy_case
   task automatic sum_case;
      run(OP_SUM, 0, 0, 3, 5, 1, 1, 8, 0, 0);
      chk({28'h0, step_count}, 32'h7);
      run(OP_SUM, 0, 0, 32'h7FFF, 1, 1, 1, 32'h8000, 0, 3'b001);
      run(OP_SUM, 0, 0, 32'h8000, 32'hFFFF, 1, 1, 32'h7FFF, 0, 3'b010);
      run(OP_SUM, 0, 0, 5, 32'hFFFB, 1, 1, 0, 0, 3'b100);
      run(OP_COPY, 0, 0, 7, 0, 1, 1, 7, 0, 3'b100);
      run(OP_SUM, 0, 0, 1, 1, 0, 0, 7, 0, 3'b100);
      run(OP_SUM, 1, 0, 32'h0001_0000, 32'hFFFF, 1, 1, 32'h0001_FFFF, 0, 0);
      chk({28'h0, step_count}, 32'hD);
   endtask : sum_case
   task automatic diff_case;
      run(OP_DIFF, 0, 0, 3, 10, 1, 1, 32'hFFF9, 0, 0);
      run(OP_DIFF, 1, 0, 0, 1, 1, 1, 32'hFFFF_FFFF, 0, 0);
      run(OP_DIFF, 0, 0, 32'h8000, 1, 1, 1, 32'h7FFF, 0, 3'b010);
      run(OP_DIFF, 0, 0, 32'h7FFF, 32'hFFFF, 1, 1, 32'h8000, 0, 3'b001);
      run(OP_DIFF, 0, 0, 9, 9, 1, 1, 0, 0, 3'b100);
   endtask : diff_case
   task automatic mul_div_case;
      run(OP_PROD, 0, 0, 32'hFFFE, 3, 1, 1, 32'hFFFA, 32'hFFFF, 3'b100);
      run(OP_PROD, 0, 0, 32'h7FFF, 32'h7FFF, 1, 1, 1, 32'h3FFF, 3'b100);
      run(OP_QUOT, 0, 0, 32'hFFF9, 2, 1, 1, 32'hFFFD, 32'hFFFF, 3'b100);
      run(OP_PROD, 1, 0, 32'h0001_0000, 32'h0001_0000, 1, 1, 0, 1, 3'b100);
      run(OP_QUOT, 0, 0, 7, 0, 1, 1, 0, 0, 3'b100);
      run(OP_QUOT, 1, 0, 32'hFFFF_FFF9, 2, 1, 1, 32'hFFFF_FFFD, 32'hFFFF_FFFF, 3'b100);
   endtask : mul_div_case
   task automatic pulse_case;
      run(OP_COPY, 0, 0, 1, 0, 1, 1, 1, 0, 3'b100);
      run(OP_COPY, 0, 1, 3, 0, 0, 0, 1, 0, 3'b100);
      run(OP_COPY, 0, 1, 2, 0, 1, 1, 2, 0, 3'b100);
      run(OP_COPY, 0, 1, 3, 0, 1, 0, 2, 0, 3'b100);
      run(OP_COPY, 0, 0, 5, 0, 1, 1, 5, 0, 3'b100);
      run(OP_COPY, 0, 0, 6, 0, 1, 1, 6, 0, 3'b100);
   endtask : pulse_case
   // back-to-back scans: pulse form writes once, continuous form on every scan
   task automatic burst_case;
      run(OP_COPY, 0, 1, 9, 0, 0, 0, 6, 0, 3'b100);
      u_scan_sequencer_model.issue_burst(OP_COPY, 0, 1, 32'h0000_0011, 0, 1, 2);
      chk({31'h0, result_valid}, 32'h0);
      chk(result.dest_lo, 32'h0000_0011);
      u_scan_sequencer_model.issue_burst(OP_SUM, 0, 0, 2, 3, 1, 2);
      chk({31'h0, result_valid}, 32'h1);
      chk(result.dest_lo, 32'h0000_0005);
   endtask : burst_case
   // mid-run reset clears every result field and the pulse edge memory
   task automatic reset_case;
      @(negedge clock);
      rst_n <= 1'b0;
      repeat (2) @(negedge clock);
      rst_n <= 1'b1;
      chk(result.dest_lo, 32'h0);
      chk(result.dest_hi, 32'h0);
      chk({28'h0, result.wr_hi, result.zero_result_flag, result.borrow_flag,
         result.carry_flag}, 32'h0);
      chk({31'h0, result_valid}, 32'h0);
      run(OP_COPY, 0, 1, 4, 0, 1, 1, 4, 0, 0);
   endtask : reset_case
   task automatic results;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // whole run is about 73 cycles, so this leaves a wide margin
   initial begin
      #100000;
      num_errors++;
      results();
   end
   initial begin
      repeat (6) @(negedge clock);
      rst_n <= 1'b1;
      chk(result.dest_lo, 32'h0);
      chk({31'h0, result_valid}, 32'h0);
      copy_case();
      sum_case();
      diff_case();
      mul_div_case();
      pulse_case();
      burst_case();
      reset_case();
      results();
   end
endmodule : plc_arith_move_unit_tb
`default_nettype wire
